// ### inc/mem_port_if.sv
// write and read port of the configuration store
// assumes both sides run on the system clock
`timescale 1ns/1ns
`default_nettype none
interface mem_port_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          wrEn;    // write strobe
  logic [AW-1:0] wrAddr;  // write address
  logic [DW-1:0] wrData;  // write data
  logic [AW-1:0] rdAddr;  // read address
  logic [DW-1:0] rdData;  // registered read data

  modport ctrl  (output wrEn, wrAddr, wrData, rdAddr, input rdData);
  modport store (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface
`default_nettype wire

// ### inc/scp_pkg.sv
// constants, types and the address map of the serial control port
// assumes a byte-wide configuration store of 128 entries behind the port
package scp_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_CH_HI   = 7;  // channel address, upper bit
  localparam int CMD_CH_LO   = 6;  // channel address, lower bit
  localparam int CMD_RD_BIT  = 5;  // high for a read
  localparam int CMD_FAM_BIT = 4;  // low selects coefficient access
  localparam int CMD_EXT_BIT = 3;  // high with bit four high selects common registers
  localparam int CMD_CNT_MSB = 2;  // count field is bits 2..0

  // ----------------------------------------------------------------
  // store layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;                   // store address width
  localparam int DATA_W = 8;                   // store data width
  localparam logic [ADDR_W-1:0] CR_BASE   = 7'h00; // per-channel regs
  localparam logic [ADDR_W-1:0] XR_BASE   = 7'h20; // common regs
  localparam logic [ADDR_W-1:0] COEF_BASE = 7'h40; // coefficients
  localparam logic [2:0]        CR_COUNT  = 3'h6;  // regs per channel
  localparam logic [2:0]        BIT_LAST  = 3'h7;  // last bit of byte
  localparam logic [7:0]        IDLE_BYTE = 8'h00; // unfilled read

  // link phases of one frame
  typedef enum logic [2:0] {
    PH_CMD,   // collecting the command byte
    PH_WR,    // collecting write data bytes
    PH_ID,    // shifting the identification byte
    PH_RD,    // shifting read data bytes
    PH_DONE   // transfer complete, waiting for select high
  } phase_e;

  // map a command and register index onto {valid, store address}
  function automatic logic [ADDR_W:0] mapAddr(
    input logic [7:0] cmd,
    input logic [2:0] idx
  );
    logic [ADDR_W-1:0] a;
    logic              ok;
    a  = COEF_BASE | ADDR_W'({cmd[CMD_CH_HI:CMD_CH_LO],
                              cmd[CMD_EXT_BIT], idx});
    ok = 1'b1;
    if (cmd[CMD_FAM_BIT] && cmd[CMD_EXT_BIT]) begin
      a = XR_BASE | ADDR_W'(idx);
    end else if (cmd[CMD_FAM_BIT]) begin
      a  = CR_BASE | ADDR_W'({cmd[CMD_CH_HI:CMD_CH_LO], idx});
      ok = (idx < CR_COUNT);
    end
    return {ok, a};
  endfunction

endpackage

// ### logic/cdc_sync.sv
// two flip-flop level synchroniser, one stage pair per bit
// assumes each bit changes at most once per several clocks
`timescale 1ns/1ns
`default_nettype none
module cdc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by the second
    logic [W-1:0] s2;  // second stage, safe to use
  } sync_s;
  sync_s sQ;
  sync_s sD;

  if (W < 1) begin : g_bad_w
    $error("cdc_sync width must be at least one");
  end

  // next state: plain shift through both stages
  always_comb begin
    sD.s1 = d;
    sD.s2 = sQ.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sQ <= '0;
    end else begin
      sQ <= sD;
    end
  end

  assign q = sQ.s2;
endmodule
`default_nettype wire

// ### logic/cfg_memory.sv
// configuration and coefficient store, one write and one read port
// assumes a single clock; contents are not cleared by reset
`timescale 1ns/1ns
`default_nettype none
module cfg_memory #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  mem_port_if.store port
);
  logic [DW-1:0] mem [2**AW];  // storage array
  logic [DW-1:0] rdQ;          // registered read word

  if (AW < 1 || DW < 1) begin : g_bad_size
    $error("cfg_memory needs nonzero address and data widths");
  end

  // read first: a same-cycle write is not seen, read out through a register
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
    rdQ <= mem[port.rdAddr];
  end

  assign port.rdData = rdQ;
endmodule
`default_nettype wire

// ### logic/serial_control_port.sv
// serial control port: command decoding, byte shifting and the store
// assumes the host drives select, shift clock and serial input; the
// shift clock may stop between bytes and outside frames
`timescale 1ns/1ns
`default_nettype none
module serial_control_port #(
  parameter logic [7:0] IdentCode = 8'hA5  // arbitrary value
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        csN,
  input  wire logic                        ctrlShiftClock,
  input  wire logic                        serIn,
  output logic                             serOut,
  output logic                             serOutEn,
  output logic                             cfgWrStrobe,
  output logic [scp_pkg::ADDR_W-1:0]       cfgWrAddr,
  output logic [scp_pkg::DATA_W-1:0]       cfgWrData
);
  import scp_pkg::*;

  // ----------------------------------------------------------------
  // link side state
  // ----------------------------------------------------------------
  // frame state: cleared whenever select is high
  typedef struct packed {
    phase_e      ph;      // where the frame stands
    logic [2:0]  bitCnt;  // bit position within the byte
    logic [7:0]  shIn;    // input shifter
    logic [7:0]  cmd;     // latched command byte
    logic [2:0]  idx;     // register index of the current byte
  } frame_s;

  // crossing state: survives select high so no toggle is lost
  typedef struct packed {
    logic               wrTog;   // flips once per stored byte
    logic [ADDR_W-1:0]  wrAddr;  // held with the write toggle
    logic [DATA_W-1:0]  wrData;  // held with the write toggle
    logic               rdTog;   // flips once per fetch request
    logic [ADDR_W-1:0]  rdAddr;  // held with the read toggle
    logic               rdOk;    // low for a missing register
    logic               ackS1;   // fetch answer, first stage
    logic               ackS2;   // fetch answer, second stage
  } xfer_s;

  // output side, clocked on the falling shift clock edge
  typedef struct packed {
    logic [7:0] outSh;  // output shifter, top bit on the pin
    logic       outEn;  // drive enable for the shared line
  } drive_s;

  // ----------------------------------------------------------------
  // system clock side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               wrSeen;   // last write toggle handled
    logic               rdSeen;   // last read toggle handled
    logic               rdPend;   // store read in flight
    logic [DATA_W-1:0]  rdHold;   // fetched byte for the link
    logic               ackTog;   // flips when rdHold is fresh
    logic               wrStb;    // one-cycle update notice
    logic [ADDR_W-1:0]  wrAddr;   // last written address
    logic [DATA_W-1:0]  wrData;   // last written data
  } core_s;

  frame_s fQ;             // frame registers
  frame_s fD;             // frame next value
  xfer_s  xQ;             // crossing registers
  xfer_s  xD;             // crossing next value
  drive_s nQ;             // output registers
  drive_s nD;             // output next value
  core_s  cQ;             // system side registers
  core_s  cD;             // system side next value

  logic              frameRst;  // select high or system reset
  logic [7:0]        newByte;   // input shifter with the new bit
  logic              byteEnd;   // this rising edge ends a byte
  logic [ADDR_W:0]   wrMap;     // {valid, address} for a write
  logic [ADDR_W:0]   rdMap;     // {valid, address} for a fetch
  logic              fetchOk;   // fetched byte has arrived
  logic [1:0]        togS;      // synchronised {write, read} toggles

  mem_port_if #(.AW(ADDR_W), .DW(DATA_W)) memPort ();

  // select high ends a frame at once, with or without a clock
  assign frameRst = csN | srst;

  // ----------------------------------------------------------------
  // link decoder, rising shift clock edge
  // ----------------------------------------------------------------
  // input bits enter from the bottom so the first is the top bit
  assign newByte = {fQ.shIn[6:0], serIn};
  assign byteEnd = (fQ.bitCnt == BIT_LAST);
  assign wrMap   = mapAddr(fQ.cmd, fQ.idx);
  assign fetchOk = (xQ.ackS2 == xQ.rdTog);

  // next state of the frame and of the crossing registers
  always_comb begin
    fD = fQ;
    xD = xQ;
    rdMap = mapAddr(fQ.cmd, fQ.idx - 3'h1);
    // fetch answer from the system side, two stages
    xD.ackS1 = cQ.ackTog;
    xD.ackS2 = xQ.ackS1;
    // the count wraps, so no pause can lose the byte position
    fD.bitCnt = fQ.bitCnt + 3'h1;
    unique case (fQ.ph)
      PH_CMD: begin
        // the first eight bits of a frame are always the command
        fD.shIn = newByte;
        if (byteEnd) begin
          fD.cmd = newByte;
          // count field gives bytes minus one, up to eight
          fD.idx = newByte[CMD_CNT_MSB:0];
          if (newByte[CMD_RD_BIT]) begin
            // read: fetch the highest register first
            fD.ph = PH_ID;
            {xD.rdOk, xD.rdAddr} =
              mapAddr(newByte, newByte[CMD_CNT_MSB:0]);
            xD.rdTog = ~xQ.rdTog;
          end else begin
            fD.ph = PH_WR;
          end
        end
      end
      PH_WR: begin
        fD.shIn = newByte;
        if (byteEnd) begin
          // family and channel pick the location of each byte
          if (wrMap[ADDR_W]) begin
            xD.wrAddr = wrMap[ADDR_W-1:0];
            xD.wrData = newByte;
            xD.wrTog  = ~xQ.wrTog;
          end
          // bytes come highest register first, down to zero
          if (fQ.idx == 3'h0) begin
            fD.ph = PH_DONE;
          end else begin
            fD.idx = fQ.idx - 3'h1;
          end
        end
      end
      PH_ID: begin
        // input is not decoded while the device answers
        if (byteEnd) begin
          fD.ph = PH_RD;
        end
      end
      PH_RD: begin
        // prefetch the next lower register at the byte's first bit
        // so the fetch has seven shift clocks to come back
        if (fQ.bitCnt == 3'h0 && fQ.idx != 3'h0) begin
          {xD.rdOk, xD.rdAddr} = rdMap;
          xD.rdTog = ~xQ.rdTog;
        end
        if (byteEnd) begin
          if (fQ.idx == 3'h0) begin
            fD.ph = PH_DONE;
          end else begin
            fD.idx = fQ.idx - 3'h1;
          end
        end
      end
      PH_DONE: begin
        // further bits are ignored until select rises
        fD.shIn = fQ.shIn;
      end
    endcase
  end

  // frame registers, cleared while select is high
  always_ff @(posedge ctrlShiftClock or posedge frameRst) begin
    if (frameRst) begin
      fQ <= '{ph: PH_CMD, default: '0};
    end else begin
      fQ <= fD;
    end
  end

  // crossing registers, cleared only by the system reset
  always_ff @(posedge ctrlShiftClock or posedge srst) begin
    if (srst) begin
      xQ <= '0;
    end else begin
      xQ <= xD;
    end
  end

  // ----------------------------------------------------------------
  // output shifter, falling shift clock edge
  // ----------------------------------------------------------------
  // the pin is driven only through the identification and read
  // bytes; otherwise it floats so input and output can share a wire
  always_comb begin
    nD = nQ;
    if (fQ.ph == PH_ID || fQ.ph == PH_RD) begin
      nD.outEn = 1'b1;
      if (fQ.bitCnt == 3'h0 && fQ.ph == PH_ID) begin
        // identification byte leads every read
        nD.outSh = IdentCode;
      end else if (fQ.bitCnt == 3'h0) begin
        // a fetch that has not come back sends idle bits
        nD.outSh = fetchOk ? cQ.rdHold : IDLE_BYTE;
      end else begin
        // top bit leaves first
        nD.outSh = {nQ.outSh[6:0], 1'b0};
      end
    end else begin
      // writes, commands and finished frames leave the line idle
      nD.outEn = 1'b0;
    end
  end

  always_ff @(negedge ctrlShiftClock or posedge frameRst) begin
    if (frameRst) begin
      nQ <= '0;
    end else begin
      nQ <= nD;
    end
  end

  assign serOut   = nQ.outSh[7];
  assign serOutEn = nQ.outEn;

  // ----------------------------------------------------------------
  // system clock side: store access
  // ----------------------------------------------------------------
  // toggles are synchronised; addresses and data held beside them
  // are stable long before a toggle arrives, so they are read as is
  cdc_sync #(.W(2)) togSync (
    .clk (mclk),
    .rst (srst),
    .d   ({xQ.wrTog, xQ.rdTog}),
    .q   (togS)
  );

  // store ports follow the held link registers
  assign memPort.wrEn   = togS[1] ^ cQ.wrSeen;
  assign memPort.wrAddr = xQ.wrAddr;
  assign memPort.wrData = xQ.wrData;
  assign memPort.rdAddr = xQ.rdAddr;

  cfg_memory #(.AW(ADDR_W), .DW(DATA_W)) store (
    .clk  (mclk),
    .port (memPort)
  );

  // handle each toggle once and answer fetches with a toggle
  always_comb begin
    cD = cQ;
    cD.wrStb  = 1'b0;
    cD.rdPend = 1'b0;
    if (togS[1] != cQ.wrSeen) begin
      // a new byte reaches the store in this cycle
      cD.wrSeen = togS[1];
      cD.wrStb  = 1'b1;
      cD.wrAddr = xQ.wrAddr;
      cD.wrData = xQ.wrData;
    end
    if (togS[0] != cQ.rdSeen) begin
      // address has been on the store port for some cycles already
      cD.rdSeen = togS[0];
      cD.rdPend = 1'b1;
    end
    if (cQ.rdPend) begin
      // missing per-channel registers read as zero
      cD.rdHold = xQ.rdOk ? memPort.rdData : IDLE_BYTE;
      cD.ackTog = ~cQ.ackTog;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cQ <= '0;
    end else begin
      cQ <= cD;
    end
  end

  // update notice for the rest of the chip
  assign cfgWrStrobe = cQ.wrStb;
  assign cfgWrAddr   = cQ.wrAddr;
  assign cfgWrData   = cQ.wrData;
endmodule
`default_nettype wire

// ### sim/scp_host.sv
// host model: drives select, shift clock and the strapped data line
// assumes the device answers on shift clock falls, msb first
`timescale 1ns/1ns
`default_nettype none
module scp_host (
  output logic      csN,
  output logic      ctrlShiftClock,
  output logic      serIn,
  input  wire logic serOut,
  input  wire logic serOutEn
);
  logic       hostBit;    // bit the host offers
  logic       hostEn;     // host drives the line
  logic [7:0] rxBuf[9];   // bytes seen after the command

  // strapped line; a released line carries the inverted host bit so stale data never passes
  always_comb begin
    serIn = serOutEn ? serOut : (hostEn ? hostBit : ~hostBit);
  end

  initial begin
    csN            = 1'b1;
    ctrlShiftClock = 1'b1;
    hostBit        = 1'b0;
    hostEn         = 1'b0;
  end

  // ------------------------------------------------------------------
  // link tasks
  // ------------------------------------------------------------------
  // up to eight bits each way; set after a fall, sampled at the rise
  task automatic xferByte(input logic [7:0] tx, input int nbits,
                          input logic drive, output logic [7:0] rx);
    rx = 8'h00;
    for (int b = 7; b > 7 - nbits; b--) begin
      ctrlShiftClock = 1'b0;
      hostEn         = drive;
      hostBit        = tx[b];
      #32;
      ctrlShiftClock = 1'b1;
      rx[b]          = serIn;
      #32;
    end
  endtask

  // whole frame; gap holds the clock high before each data byte, cut sends
  // a partial byte before the abort
  task automatic frame(input logic [7:0] cmd, input int nb,
                       input logic [63:0] wd, input int gap, input int cut);
    logic [7:0] rx;
    // every link edge lands on a system clock fall, away from sampling
    csN = 1'b0;
    #24;
    xferByte(cmd, 8, 1'b1, rx);
    for (int k = 0; k < nb; k++) begin
      #(gap);
      xferByte(wd[8*(int'(cmd[2:0])-k)+:8], 8, !cmd[5], rx);
      rxBuf[k] = rx;
    end
    if (cut > 0) xferByte(8'hFF, cut, !cmd[5], rx);
    #104;
    csN    = 1'b1;
    hostEn = 1'b0;
    #104;
  endtask
endmodule
`default_nettype wire

// ### sim/serial_control_port_chk.sv
// checker on the ports of the serial control port
// assumes binding onto the top module; two clock domains
`timescale 1ns/1ns
`default_nettype none
module serial_control_port_chk #(
  parameter logic [7:0] IdentCode = 8'hA5  // arbitrary value
) (
  input wire logic                  mclk,
  input wire logic                  srst,
  input wire logic                  csN,
  input wire logic                  ctrlShiftClock,
  input wire logic                  serIn,
  input wire logic                  serOut,
  input wire logic                  serOutEn,
  input wire logic                  cfgWrStrobe,
  input wire logic [scp_pkg::ADDR_W-1:0] cfgWrAddr,
  input wire logic [scp_pkg::DATA_W-1:0] cfgWrData
);
  import scp_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;  // rises since select fell
    logic       rd;   // command bit five
  } rise_s;
  rise_s h_q;
  rise_s h_d;

  // rise counter; select high clears it like the frame logic
  always_comb begin
    h_d = h_q;
    if (h_q.cnt == 8'h02) h_d.rd = serIn;
    if (h_q.cnt != 8'hFF) h_d.cnt = h_q.cnt + 8'h01;
  end
  always_ff @(posedge ctrlShiftClock or posedge csN or posedge srst) begin
    if (csN || srst) h_q <= '0;
    else h_q <= h_d;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_RESET_QUIET: assert property (@(posedge mclk)
    srst |=> !cfgWrStrobe && !serOutEn) else $error("outputs busy after reset");
  AST_CS_ABORT: assert property (@(posedge mclk) disable iff (srst)
    csN |-> !serOutEn) else $error("output driven while deselected");
  AST_EN_AFTER_CMD: assert property (@(posedge mclk) disable iff (srst)
    serOutEn |-> h_q.cnt >= 8) else $error("output before command end");
  AST_ID_START: assert property (@(posedge mclk) disable iff (srst)
    $rose(serOutEn) |-> !ctrlShiftClock && serOut == IdentCode[7])
    else $error("reply start wrong");
  AST_ID_BITS: assert property (@(posedge ctrlShiftClock)
    disable iff (srst || csN) serOutEn && h_q.cnt >= 8 && h_q.cnt < 16
    |-> serOut == IdentCode[15 - h_q.cnt]) else $error("ident bit wrong");
  AST_OUT_ON_FALL: assert property (@(posedge mclk)
    disable iff (srst || csN) ctrlShiftClock && $past(ctrlShiftClock)
    && $past(csN) == 1'b0 |-> $stable(serOut) && $stable(serOutEn))
    else $error("output moved while clock high");
  AST_IDLE_ON_WRITE: assert property (@(posedge mclk) disable iff (srst)
    serOutEn |-> h_q.rd) else $error("output driven on a write");
  AST_STROBE_ON_WRITE: assert property (@(posedge mclk) disable iff (srst)
    cfgWrStrobe |-> !h_q.rd && h_q.cnt >= 16) else $error("stray store write");
  AST_STROBE_PULSE: assert property (@(posedge mclk) disable iff (srst)
    cfgWrStrobe |=> !cfgWrStrobe) else $error("strobe too long");
  AST_WR_HOLDS: assert property (@(posedge mclk) disable iff (srst)
    !cfgWrStrobe ##1 !cfgWrStrobe |-> $stable(cfgWrAddr) && $stable(cfgWrData))
    else $error("write bus moved without strobe");

  COV_READ: cover property (@(posedge mclk) $rose(serOutEn));
  COV_WRITE: cover property (@(posedge mclk) cfgWrStrobe);
  COV_ABORT: cover property (@(posedge mclk) serOutEn ##1 csN);
endmodule
`default_nettype wire

// ### sim/serial_control_port_tb.sv
// self-checking bench: host model frames, store writes logged and read
// back; assumes scp_pkg, the design and the host model are compiled
`timescale 1ns/1ns
`default_nettype none
module serial_control_port_tb;
  import scp_pkg::*;
  localparam logic [7:0] ID = 8'h3C;  // arbitrary value
  logic              mclk;
  logic              srst;
  logic              csN;
  logic              ctrlShiftClock;
  logic              serIn;
  logic              serOut;
  logic              serOutEn;
  logic              cfgWrStrobe;
  logic [ADDR_W-1:0] cfgWrAddr;
  logic [DATA_W-1:0] cfgWrData;
  int                fails;
  int                cmpCount;
  logic [7:0]        shadow[128];  // expected store contents
  logic [14:0]       wrLog[$];     // store writes seen

  serial_control_port #(.IdentCode(ID)) u_serial_control_port (
    .mclk, .srst, .csN, .ctrlShiftClock, .serIn, .serOut, .serOutEn,
    .cfgWrStrobe, .cfgWrAddr, .cfgWrData);
  scp_host u_scp_host (.csN, .ctrlShiftClock, .serIn, .serOut, .serOutEn);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (cfgWrStrobe === 1'b1) wrLog.push_back({cfgWrAddr, cfgWrData});

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [14:0] exp, got);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected store address; bit 7 marks an index with no register
  function automatic logic [7:0] expAddr(input logic [7:0] c, input int i);
    if (!c[4]) return {2'b01, c[7:6], c[3], 3'(i)};
    if (c[3]) return {5'b00100, 3'(i)};
    return {i > 5, 2'b00, c[7:6], 3'(i)};
  endfunction

  // write frame of full bytes (plus cut bits), compare each store write
  task automatic doWrite(input logic [7:0] c, input logic [63:0] wd,
                         input int gap, input int cut, input int full);
    int         n;
    int         i;
    logic [7:0] a;
    wrLog.delete();
    u_scp_host.frame(c, full, wd, gap, cut);
    n = 0;
    for (int k = 0; k < full; k++) begin
      i = int'(c[2:0]) - k;
      a = expAddr(c, i);
      if (!a[7]) begin
        shadow[a[6:0]] = wd[8*i+:8];
        check("write", {a[6:0], wd[8*i+:8]}, n < wrLog.size() ? wrLog[n] : 'x);
        n++;
      end
    end
    check("write count", 15'(n), 15'(wrLog.size()));
  endtask

  task automatic doRead(input logic [7:0] c);
    int         i;
    logic [7:0] a;
    wrLog.delete();
    u_scp_host.frame(c, int'(c[2:0]) + 2, 64'h0, 0, 0);
    check("ident", 15'(ID), 15'(u_scp_host.rxBuf[0]));
    for (int k = 0; k <= int'(c[2:0]); k++) begin
      i = int'(c[2:0]) - k;
      a = expAddr(c, i);
      check("read", 15'(a[7] ? 8'h00 : shadow[a[6:0]]), 15'(u_scp_host.rxBuf[k+1]));
    end
    check("read writes", 15'h0000, 15'(wrLog.size()));
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    doWrite(8'h51, 64'h0000_0000_0000_C3A1, 0, 0, 2);
    doWrite(8'h97, 64'hF0E1_D2C3_B4A5_9687, 200, 0, 8);
    doWrite(8'h1F, 64'h1111_2222_3333_4444, 0, 3, 2);
    doWrite(8'h1F, 64'h0123_4567_89AB_CDEF, 0, 0, 8);
    doWrite(8'hCC, 64'h0000_0011_2233_4455, 0, 0, 5);
    doRead(8'h71);
    doRead(8'hB7);
    doRead(8'h3F);
    doRead(8'hEC);
    u_scp_host.frame(8'h3F, 3, 64'h0, 0, 4);
    doRead(8'h71);
    tally_and_finish();
  end

  // watchdog: the frames need well under 200 microseconds
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule

bind serial_control_port serial_control_port_chk #(.IdentCode(IdentCode))
  u_serial_control_port_chk (.mclk(mclk), .srst(srst), .csN(csN),
  .ctrlShiftClock(ctrlShiftClock), .serIn(serIn), .serOut(serOut),
  .serOutEn(serOutEn), .cfgWrStrobe(cfgWrStrobe), .cfgWrAddr(cfgWrAddr),
  .cfgWrData(cfgWrData));
`default_nettype wire
